// File: design/sev_pkg.sv
// Purpose: Shared constants and types for the swing, equalization and verifier registers
// Assumes: Byte-wide registers reached over the two-wire configuration port
// Notes:   Tables hold decoded analog settings in percent or half-dB steps
package sev_pkg;
	// ************************************************************
	// Configuration port
	// ************************************************************
	localparam logic [6:0] DEV_ADDR  = 7'h2A; // Arbitrary bus address value
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ************************************************************
	// Register offsets and reset values
	// ************************************************************
	localparam logic [7:0] ADDR_APPLY  = 8'h0A;
	localparam logic [7:0] ADDR_SWING  = 8'h0C;
	localparam logic [7:0] ADDR_EQ     = 8'h0D;
	localparam logic [7:0] ADDR_PVCTL  = 8'h0E;
	localparam logic [7:0] ADDR_PVSTAT = 8'h0F;
	localparam logic [7:0] SWING_RST   = 8'h00;
	localparam logic [7:0] EQ_RST      = 8'h01;
	localparam logic [7:0] PVCTL_RST   = 8'h00;
	localparam logic [7:0] PVSTAT_RST  = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int APPLY_BIT      = 2;
	localparam int SWING_DATA_LSB = 5;
	localparam int SWING_CLK_LSB  = 2;
	localparam int TAP_LSB        = 0;
	localparam int EQ_DATA_LSB    = 3;
	localparam int EQ_CLK_LSB     = 1;
	localparam int PULSE_LSB      = 4;
	localparam int LOAD_LSB       = 0;

	// ************************************************************
	// Lane verifier settings layout
	// ************************************************************
	localparam int LANES    = 4;
	localparam int SET_W    = 28;
	localparam int SEL_LSB  = 0;
	localparam int LEN_LSB  = 3;
	localparam int TO_BIT   = 6;
	localparam int CP20_BIT = 7;
	localparam int CP_LSB   = 8;

	// Pin synchroniser reset: {cfgSource, strap, sda, scl}
	localparam logic [3:0] PIN_SYNC_RST = 4'hB;

	// ************************************************************
	// Decode tables
	// ************************************************************
	localparam logic signed [5:0] SWING_PCT [8] = '{6'sd0, 6'sd7, 6'sd13, 6'sd18,
		-6'sd30, -6'sd22, -6'sd15, -6'sd7};
	localparam logic [5:0] EQ_DATA_HDB [8] = '{6'h00, 6'h09, 6'h0D, 6'h11,
		6'h15, 6'h18, 6'h1C, 6'h21};
	localparam logic [5:0] EQ_CLK_HDB [4] = '{6'h00, 6'h03, 6'h06, 6'h00};
	localparam logic [2:0] TAP_HDB [4] = '{3'h0, 3'h4, 3'h0, 3'h0};

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h3,
		ST_PTR       = 4'h2,
		ST_PTR_ACK   = 4'h6,
		ST_WDATA     = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA     = 4'h4,
		ST_RDATA_ACK = 4'hC
	} sev_state_e;

	typedef enum logic [2:0] {
		MODE_OFF    = 3'h0,
		MODE_PRBS   = 3'h1,
		MODE_CLOCK  = 3'h2,
		MODE_CUSTOM = 3'h3,
		MODE_TIMING = 3'h4
	} sev_mode_e;
endpackage : sev_pkg

// File: design/sev_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for the slow pins
// Assumes: Pins change far slower than core_clk
// Notes:   A level counts once stages two and three agree
`timescale 1ns/10ps
module sev_pin_sync
	import sev_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Pins in, filtered levels out
	input  wire logic [3:0] pinIn,
	output logic      [3:0] pinLevel
);
	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] stage3;

	// ************************************************************
	// Per-pin chain
	// ************************************************************
	for (genvar i = 0; i < 4; i++)
	begin : g_bit
		// Stage one only feeds stage two, keeping metastability contained
		always_ff @(posedge core_clk)
		begin
			if (sys_rst)
			begin
				stage1[i]   <= PIN_SYNC_RST[i];
				stage2[i]   <= PIN_SYNC_RST[i];
				stage3[i]   <= PIN_SYNC_RST[i];
				pinLevel[i] <= PIN_SYNC_RST[i];
			end
			else
			begin
				stage1[i] <= pinIn[i];
				stage2[i] <= stage1[i];
				stage3[i] <= stage2[i];
				if (stage2[i] == stage3[i])
					pinLevel[i] <= stage3[i];
			end
		end
	end
endmodule : sev_pin_sync

// File: design/sev_lane_hold.sv
// Purpose: Per-lane pass-through and hold of pattern-verifier settings
// Assumes: Settings come from same-clock control registers
// Notes:   One cycle from settings to lane output while loading
`timescale 1ns/10ps
module sev_lane_hold
	import sev_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Control side
	input  wire logic             load,
	input  wire logic [SET_W-1:0] settings,
	// Lane side
	output logic      [SET_W-1:0] heldSettings,
	output logic      [2:0]       mode
);
	sev_mode_e next_mode;

	// Pattern select decode; upper half is timing only
	always_comb
	begin
		case (settings[SEL_LSB +: 3])
			3'h0:    next_mode = MODE_OFF;
			3'h1:    next_mode = MODE_PRBS;
			3'h2:    next_mode = MODE_CLOCK;
			3'h3:    next_mode = MODE_CUSTOM;
			default: next_mode = MODE_TIMING;
		endcase
	end

	// Follow while loading, freeze otherwise
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			heldSettings <= '0;
			mode         <= MODE_OFF;
		end
		else if (load)
		begin
			heldSettings <= settings;
			mode         <= next_mode;
		end
	end
endmodule : sev_lane_hold

// File: design/sev_csr.sv
// Purpose: Swing, pre-emphasis, equalization and lane verifier registers
// Assumes: Two-wire configuration port, pins sampled on core_clk at 25 MHz
// Notes:   Swing and equalization reach the lanes only through the apply bit
`timescale 1ns/10ps
module sev_csr
	import sev_pkg::*;
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	// Two-wire configuration port
	input  wire logic                   cfgSclIn,
	input  wire logic                   cfgSdaIn,
	output logic                        cfgSdaOut,
	output logic                        cfgSdaOe,
	// Strap pins
	input  wire logic                   preEmphStrapPin,
	input  wire logic                   cfgSourcePin,
	// Verifier settings from the upper registers
	input  wire logic [2:0]             verifierPatternSelect,
	input  wire logic [2:0]             verifierSequenceLength,
	input  wire logic                   verifierTimingOption,
	input  wire logic                   customPatternWide,
	input  wire logic [19:0]            customPatternBits,
	// Lane status
	input  wire logic [LANES-1:0]       laneTimingPulse,
	input  wire logic [LANES-1:0]       laneMismatch,
	input  wire logic [LANES-1:0]       laneTraining,
	// Lane verifier settings
	output logic      [LANES*SET_W-1:0] laneVerifierSettings,
	output logic      [LANES*3-1:0]     laneVerifierMode,
	// Applied analog settings
	output logic                        dataSwingFromResistor,
	output logic signed [5:0]           dataSwingPercent,
	output logic                        clockSwingFollowsRate,
	output logic signed [5:0]           clockSwingPercent,
	output logic      [2:0]             postCursorHalfDb,
	output logic      [5:0]             dataEqHalfDb,
	output logic      [5:0]             clockEqHalfDb
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic       [3:0]       pinLevel;
	logic                   sclS;
	logic                   sdaS;
	logic                   strapS;
	logic                   cfgSrcS;
	logic                   sclPrev;
	logic                   sdaPrev;
	logic                   sclRise;
	logic                   sclFall;
	logic                   startSeen;
	logic                   stopSeen;
	sev_state_e             state;
	logic       [3:0]       bitCnt;
	logic       [7:0]       shift;
	logic       [7:0]       ptr;
	logic                   masterAck;
	logic                   wrStb;
	logic       [7:0]       rdData;
	logic                   applyPulse;
	logic       [2:0]       dataSwing;
	logic       [2:0]       clkSwing;
	logic       [1:0]       tap;
	logic       [2:0]       eqData;
	logic       [1:0]       eqClk;
	logic       [LANES-1:0] loadBits;
	logic       [LANES-1:0] pulseBits;
	logic       [7:0]       statusReg;
	logic       [SET_W-1:0] settingsBus;

	// ************************************************************
	// Pin capture and bus conditions
	// ************************************************************
	sev_pin_sync u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinIn    ({cfgSourcePin, preEmphStrapPin, cfgSdaIn, cfgSclIn}),
		.pinLevel (pinLevel)
	);

	assign sclS    = pinLevel[0];
	assign sdaS    = pinLevel[1];
	assign strapS  = pinLevel[2];
	assign cfgSrcS = pinLevel[3];

	// Previous filtered levels for edge finding
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	assign sclRise   = sclS & ~sclPrev;
	assign sclFall   = ~sclS & sclPrev;
	assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
	assign stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;
	assign wrStb     = (state == ST_WDATA) && sclFall && (bitCnt == BYTE_BITS);

	// ************************************************************
	// Two-wire slave sequencer
	// ************************************************************
	// Bits sampled on SCL rise, SDA changed only after SCL fall
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state     <= ST_IDLE;
			bitCnt    <= 4'h0;
			shift     <= 8'h00;
			ptr       <= 8'h00;
			masterAck <= 1'b0;
			cfgSdaOe  <= 1'b0;
		end
		else if (startSeen)
		begin
			state    <= ST_ADDR;
			bitCnt   <= 4'h0;
			cfgSdaOe <= 1'b0;
		end
		else if (stopSeen)
		begin
			state    <= ST_IDLE;
			cfgSdaOe <= 1'b0;
		end
		else
		begin
			case (state)
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (sclRise && bitCnt != BYTE_BITS)
					begin
						shift  <= {shift[6:0], sdaS};
						bitCnt <= bitCnt + 4'h1;
					end
					else if (sclFall && bitCnt == BYTE_BITS)
					begin
						cfgSdaOe <= 1'b1;
						if (state == ST_ADDR)
						begin
							// Foreign address: drop off the bus until next start
							state    <= (shift[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
							cfgSdaOe <= (shift[7:1] == DEV_ADDR);
						end
						else if (state == ST_PTR)
						begin
							ptr   <= shift;
							state <= ST_PTR_ACK;
						end
						else
						begin
							ptr   <= ptr + 8'h01;
							state <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (sclFall)
					begin
						bitCnt <= 4'h0;
						if (shift[0])
						begin
							state    <= ST_RDATA;
							shift    <= rdData;
							cfgSdaOe <= ~rdData[7];
						end
						else
						begin
							state    <= ST_PTR;
							cfgSdaOe <= 1'b0;
						end
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK:
				begin
					if (sclFall)
					begin
						state    <= ST_WDATA;
						bitCnt   <= 4'h0;
						cfgSdaOe <= 1'b0;
					end
				end
				ST_RDATA:
				begin
					if (sclRise)
						bitCnt <= bitCnt + 4'h1;
					else if (sclFall && bitCnt == BYTE_BITS)
					begin
						state    <= ST_RDATA_ACK;
						ptr      <= ptr + 8'h01;
						cfgSdaOe <= 1'b0;
					end
					else if (sclFall)
					begin
						shift    <= {shift[6:0], 1'b0};
						cfgSdaOe <= ~shift[6];
					end
				end
				ST_RDATA_ACK:
				begin
					if (sclRise)
						masterAck <= ~sdaS;
					else if (sclFall && masterAck)
					begin
						state    <= ST_RDATA;
						bitCnt   <= 4'h0;
						shift    <= rdData;
						cfgSdaOe <= ~rdData[7];
					end
					else if (sclFall)
						state <= ST_IDLE;
				end
				default:
				begin
					state    <= ST_IDLE;
					cfgSdaOe <= 1'b0;
				end
			endcase
		end
	end

	// Open-drain: only ever pulls low
	always_ff @(posedge core_clk)
	begin
		cfgSdaOut <= 1'b0;
	end

	// ************************************************************
	// Read mux
	// ************************************************************
	always_comb
	begin
		case (ptr)
			ADDR_SWING:  rdData = {dataSwing, clkSwing, tap};
			ADDR_EQ:     rdData = {EQ_RST[7:6], eqData, eqClk, EQ_RST[0]};
			ADDR_PVCTL:  rdData = {pulseBits, loadBits};
			ADDR_PVSTAT: rdData = statusReg;
			default:     rdData = 8'h00;
		endcase
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	// Swing fields, any code stored as written
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dataSwing <= SWING_RST[SWING_DATA_LSB +: 3];
			clkSwing  <= SWING_RST[SWING_CLK_LSB +: 3];
		end
		else if (wrStb && ptr == ADDR_SWING)
		begin
			dataSwing <= shift[SWING_DATA_LSB +: 3];
			clkSwing  <= shift[SWING_CLK_LSB +: 3];
		end
	end

	// Tap: pin control overrides software, software writes lost meanwhile
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			tap <= SWING_RST[TAP_LSB +: 2];
		else if (!cfgSrcS)
			tap <= {1'b0, strapS};
		else if (wrStb && ptr == ADDR_SWING)
			tap <= shift[TAP_LSB +: 2];
	end

	// Equalization fields; reserved bits never stored
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			eqData <= EQ_RST[EQ_DATA_LSB +: 3];
			eqClk  <= EQ_RST[EQ_CLK_LSB +: 2];
		end
		else if (wrStb && ptr == ADDR_EQ)
		begin
			eqData <= shift[EQ_DATA_LSB +: 3];
			eqClk  <= shift[EQ_CLK_LSB +: 2];
		end
	end

	// Load bits written; pulse bits are owned by the lanes
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			loadBits  <= PVCTL_RST[LOAD_LSB +: LANES];
			pulseBits <= PVCTL_RST[PULSE_LSB +: LANES];
		end
		else
		begin
			pulseBits <= laneTimingPulse;
			if (wrStb && ptr == ADDR_PVCTL)
				loadBits <= shift[LOAD_LSB +: LANES];
		end
	end

	// Status is live lane state, host writes have no effect
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			statusReg <= PVSTAT_RST;
		else
			statusReg <= {laneMismatch, laneTraining};
	end

	// Self-clearing apply: a one-cycle pulse, reads back zero
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			applyPulse <= 1'b0;
		else
			applyPulse <= wrStb && (ptr == ADDR_APPLY) && shift[APPLY_BIT];
	end

	// ************************************************************
	// Applied lane settings
	// ************************************************************
	// Staged so a half-written setup never reaches the lanes
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dataSwingFromResistor <= 1'b1;
			dataSwingPercent      <= SWING_PCT[0];
			clockSwingFollowsRate <= 1'b1;
			clockSwingPercent     <= SWING_PCT[0];
			postCursorHalfDb      <= TAP_HDB[0];
			dataEqHalfDb          <= EQ_DATA_HDB[0];
			clockEqHalfDb         <= EQ_CLK_HDB[0];
		end
		else if (applyPulse)
		begin
			dataSwingFromResistor <= (dataSwing == 3'h0);
			dataSwingPercent      <= SWING_PCT[dataSwing];
			clockSwingFollowsRate <= (clkSwing == 3'h0);
			clockSwingPercent     <= SWING_PCT[clkSwing];
			postCursorHalfDb      <= TAP_HDB[tap];
			dataEqHalfDb          <= EQ_DATA_HDB[eqData];
			clockEqHalfDb         <= EQ_CLK_HDB[eqClk];
		end
	end

	// ************************************************************
	// Lane verifier hold
	// ************************************************************
	assign settingsBus = {customPatternBits, customPatternWide, verifierTimingOption,
		verifierSequenceLength, verifierPatternSelect};

	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		sev_lane_hold u_lane (
			.core_clk     (core_clk),
			.sys_rst      (sys_rst),
			.load         (loadBits[g]),
			.settings     (settingsBus),
			.heldSettings (laneVerifierSettings[g*SET_W +: SET_W]),
			.mode         (laneVerifierMode[g*3 +: 3])
		);
	end

	// ************************************************************
	// Checks
	// ************************************************************
	tap_strap_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			!cfgSrcS |=> tap == {1'b0, $past(strapS)})
		else $error("tap not following strap under pin control");

	apply_gate_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			!applyPulse |=> $stable(dataEqHalfDb) && $stable(dataSwingPercent))
		else $error("lane setting changed without apply");

	eq_decode_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			applyPulse |=> dataEqHalfDb == EQ_DATA_HDB[$past(eqData)])
		else $error("data equalization decode wrong");

	swing_zero_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			applyPulse |=> dataSwingFromResistor == ($past(dataSwing) == 3'h0))
		else $error("resistor swing select wrong");

	eq_reserved_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			ptr == ADDR_EQ |-> rdData[0] && rdData[7:6] == 2'b00)
		else $error("reserved equalization bits wrong");

	status_track_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			##1 1'b1 |-> statusReg == {$past(laneMismatch), $past(laneTraining)})
		else $error("status not tracking lanes");

	load_pass_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			loadBits[0] |=> laneVerifierSettings[SET_W-1:0] == $past(settingsBus))
		else $error("lane zero not passing settings");

	load_hold_a:
		assert property (@(posedge core_clk) disable iff (sys_rst)
			!loadBits[1] |=> $stable(laneVerifierSettings[2*SET_W-1:SET_W]))
		else $error("lane one settings moved while held");

	reset_defaults_a:
		assert property (@(posedge core_clk)
			sys_rst |=> state == ST_IDLE && loadBits == 4'h0 && eqData == 3'h0
				&& dataSwing == 3'h0 && statusReg == PVSTAT_RST)
		else $error("defaults not restored by reset");
endmodule : sev_csr

// File: bench/sev_host_model.sv
// Purpose: Two-wire host model for the configuration port
// Assumes: Bench builds the open-drain data line with a pull-up
// Notes:   Half bit of 10 clocks keeps each phase above 5
`timescale 1ns/10ps
module sev_host_model
	import sev_pkg::*;
(
	// Clock and line level
	input  wire logic core_clk,
	input  wire logic sdaLine,
	// Driven lines
	output logic      sclOut,
	output logic      sdaLow
);
	// ********
	// Bus primitives
	// ********
	// Idle bus: clock high, data released
	initial
	begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end

	// Step just past an edge so changes never race the sampler
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// Data moves mid-low phase only; a high drive means release
	task automatic bitXfer(input logic b, output logic r);
		tick(6);
		sdaLow = ~b;
		tick(4);
		sclOut = 1'b1;
		tick(5);
		r = sdaLine;
		tick(5);
		sclOut = 1'b0;
	endtask : bitXfer

	task automatic startBus();
		tick(10);
		sdaLow = 1'b1;
		tick(10);
		sclOut = 1'b0;
	endtask : startBus

	task automatic stopBus();
		tick(6);
		sdaLow = 1'b1;
		tick(4);
		sclOut = 1'b1;
		tick(10);
		sdaLow = 1'b0;
		tick(10);
	endtask : stopBus

	// MSB first; ack high when the device pulled the line
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitXfer(d[i], r);
		bitXfer(1'b1, r);
		ack = ~r;
	endtask : sendByte

	task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] dat, output logic [2:0] acks);
		startBus();
		sendByte({dev, 1'b0}, acks[2]);
		sendByte(ptr, acks[1]);
		sendByte(dat, acks[0]);
		stopBus();
	endtask : writeReg

	// Pointer write, then one byte read closed by a no-ack
	task automatic readReg(input logic [7:0] ptr, output logic [7:0] dat);
		logic a;
		startBus();
		sendByte({DEV_ADDR, 1'b0}, a);
		sendByte(ptr, a);
		stopBus();
		startBus();
		sendByte({DEV_ADDR, 1'b1}, a);
		for (int i = 7; i >= 0; i--)
			bitXfer(1'b1, dat[i]);
		bitXfer(1'b1, a);
		stopBus();
	endtask : readReg

	// Swing, tap and EQ reach the lanes only after this
	task automatic applySettings(output logic [2:0] acks);
		writeReg(DEV_ADDR, ADDR_APPLY, 8'h04, acks);
	endtask : applySettings
endmodule : sev_host_model

// File: bench/swing_eq_pattern_verifier_csr_bench.sv
// Purpose: Self-checking bench for swing, EQ and verifier registers
// Assumes: Host model speaks the two-wire port
// Notes:   Expected codes come from the bench's own tables
`timescale 1ns/10ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module swing_eq_pattern_verifier_csr_bench
	import sev_pkg::*;
();
	// ********
	// Design and host
	// ********
	logic core_clk, sys_rst, cfgSclIn, cfgSdaIn, cfgSdaOut, cfgSdaOe, sdaLow;
	logic preEmphStrapPin, cfgSourcePin, verifierTimingOption, customPatternWide;
	logic [2:0] verifierPatternSelect, verifierSequenceLength, acks, cd;
	logic [19:0] customPatternBits;
	logic [3:0] laneTimingPulse, laneMismatch, laneTraining;
	logic [LANES*SET_W-1:0] laneVerifierSettings;
	logic [11:0] laneVerifierMode;
	logic dataSwingFromResistor, clockSwingFollowsRate;
	logic signed [5:0] dataSwingPercent, clockSwingPercent;
	logic [2:0] postCursorHalfDb;
	logic [5:0] dataEqHalfDb, clockEqHalfDb;
	logic [7:0] rd;
	int failures, nCompared;
	logic [5:0] pct [8] = '{6'h00, 6'h07, 6'h0D, 6'h12, 6'h22, 6'h2A, 6'h31, 6'h39};
	logic [5:0] dEq [8] = '{6'h00, 6'h09, 6'h0D, 6'h11, 6'h15, 6'h18, 6'h1C, 6'h21};
	logic [5:0] cEq [4] = '{6'h00, 6'h03, 6'h06, 6'h00};

	// Open drain with pull-up: low when anyone pulls
	assign cfgSdaIn = ~(sdaLow | (cfgSdaOe & ~cfgSdaOut));
	sev_host_model i_host (.core_clk, .sdaLine(cfgSdaIn), .sclOut(cfgSclIn), .sdaLow);
	sev_csr i_dut (.core_clk, .sys_rst, .cfgSclIn, .cfgSdaIn, .cfgSdaOut, .cfgSdaOe,
		.preEmphStrapPin, .cfgSourcePin, .verifierPatternSelect, .verifierSequenceLength,
		.verifierTimingOption, .customPatternWide, .customPatternBits, .laneTimingPulse,
		.laneMismatch, .laneTraining, .laneVerifierSettings, .laneVerifierMode,
		.dataSwingFromResistor, .dataSwingPercent, .clockSwingFollowsRate,
		.clockSwingPercent, .postCursorHalfDb, .dataEqHalfDb, .clockEqHalfDb);

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i_host.writeReg(DEV_ADDR, p, d, acks);
		`CHK("ack", 3'h7, acks)
	endtask : wr

	task automatic chkRd(input logic [7:0] p, input logic [7:0] e);
		i_host.readReg(p, rd);
		`CHK($sformatf("reg %h", p), e, rd)
	endtask : chkRd

	task automatic checkDefaults();
		chkRd(ADDR_SWING, 8'h00);
		chkRd(ADDR_EQ, 8'h01);
		chkRd(ADDR_PVCTL, 8'h00);
		chkRd(ADDR_PVSTAT, 8'h00);
		chkRd(ADDR_APPLY, 8'h00);
		`CHK("dflt", 4'hC, {dataSwingFromResistor, clockSwingFollowsRate, cfgSdaOut, cfgSdaOe})
		`CHK("dfltLvl", 15'h0, {postCursorHalfDb, dataEqHalfDb, clockEqHalfDb})
	endtask : checkDefaults

	task automatic complete_run();
		$display("compared %0d failures %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Watchdog, well past the expected run
	initial
	begin
		repeat (60000) @(posedge core_clk);
		failures++;
		complete_run();
	end

	// ********
	// Test sequence
	// ********
	initial
	begin
		{sys_rst, cfgSourcePin, preEmphStrapPin} = 3'h7;
		{verifierTimingOption, customPatternWide} = 2'h3;
		verifierPatternSelect = 3'h0;
		verifierSequenceLength = 3'h5;
		customPatternBits = 20'hA5C3F;
		{laneTimingPulse, laneMismatch, laneTraining} = 12'h000;
		failures = 0;
		nCompared = 0;
		i_host.tick(10);
		sys_rst = 1'b0;
		i_host.tick(4);
		checkDefaults();
		// Every swing, tap and EQ code; lanes change only on apply
		for (int c = 0; c < 8; c++)
		begin
			cd = c[2:0];
			wr(ADDR_SWING, {cd, cd, cd[1:0]});
			wr(ADDR_EQ, {2'h3, cd, cd[1:0], 1'b0});
			chkRd(ADDR_EQ, {2'h0, cd, cd[1:0], 1'b1});
			`CHK("held", pct[c == 0 ? 0 : c - 1], dataSwingPercent)
			i_host.applySettings(acks);
			i_host.tick(2);
			`CHK("dSw", pct[c], dataSwingPercent)
			`CHK("cSw", pct[c], clockSwingPercent)
			`CHK("dRes", c == 0, dataSwingFromResistor)
			`CHK("cRate", c == 0, clockSwingFollowsRate)
			`CHK("tap", cd[1:0] == 2'h1 ? 3'h4 : 3'h0, postCursorHalfDb)
			`CHK("dEq", dEq[c], dataEqHalfDb)
			`CHK("cEq", cEq[c % 4], clockEqHalfDb)
		end
		// Strap takes the tap over; host tap writes are dropped
		cfgSourcePin = 1'b0;
		i_host.tick(8);
		chkRd(ADDR_SWING, 8'hFD);
		wr(ADDR_SWING, 8'h00);
		chkRd(ADDR_SWING, 8'h01);
		preEmphStrapPin = 1'b0;
		i_host.tick(8);
		chkRd(ADDR_SWING, 8'h00);
		cfgSourcePin = 1'b1;
		i_host.tick(8);
		wr(ADDR_SWING, 8'h03);
		chkRd(ADDR_SWING, 8'h03);
		// Loading lanes follow the settings, released lanes hold
		wr(ADDR_PVCTL, 8'h0F);
		for (int s = 0; s < 8; s++)
		begin
			// Every settings field moves, so a crossed lane bit shows up
			verifierPatternSelect = 3'(s);
			verifierSequenceLength = 3'(7 - s);
			{customPatternWide, verifierTimingOption} = 2'(s);
			customPatternBits = {5{4'(s)}};
			i_host.tick(2);
			`CHK("mode", s > 3 ? 3'h4 : 3'(s), laneVerifierMode[11:9])
			`CHK("set", {{5{4'(s)}}, 2'(s), 3'(7 - s), 3'(s)}, laneVerifierSettings[111:84])
		end
		verifierPatternSelect = 3'h2;
		i_host.tick(2);
		wr(ADDR_PVCTL, 8'h05);
		verifierPatternSelect = 3'h1;
		i_host.tick(2);
		`CHK("load", 3'h1, laneVerifierMode[2:0])
		`CHK("hold", 3'h2, laneVerifierMode[5:3])
		wr(ADDR_PVCTL, 8'h00);
		verifierPatternSelect = 3'h3;
		i_host.tick(2);
		`CHK("hold", 3'h1, laneVerifierMode[8:6])
		// Live lane flags, read-only to the host
		{laneTimingPulse, laneMismatch, laneTraining} = 12'h9A5;
		wr(ADDR_PVSTAT, 8'h00);
		chkRd(ADDR_PVSTAT, 8'hA5);
		chkRd(ADDR_PVCTL, 8'h90);
		// Complementary pattern so every flag bit is seen both ways
		{laneTimingPulse, laneMismatch, laneTraining} = 12'h65A;
		chkRd(ADDR_PVSTAT, 8'h5A);
		chkRd(ADDR_PVCTL, 8'h60);
		chkRd(8'h20, 8'h00);
		i_host.writeReg(7'h15, ADDR_SWING, 8'hE0, acks);
		chkRd(ADDR_SWING, 8'h03);
		// Second reset in mid-run restores every default
		{laneTimingPulse, laneMismatch, laneTraining} = 12'h000;
		sys_rst = 1'b1;
		i_host.tick(4);
		sys_rst = 1'b0;
		i_host.tick(4);
		`CHK("lanes", 12'h000, laneVerifierMode)
		checkDefaults();
		complete_run();
	end
endmodule : swing_eq_pattern_verifier_csr_bench
